//--- sonc_pkg.sv
// shared constants and types for the sense / overvoltage / negative-current register group
package sonc_pkg;

  // ---------------------------------------------------------------
  // register offsets on the byte bus
  // ---------------------------------------------------------------
  localparam logic [7:0] SONC_ADDR_SENSE = 8'hB3;  // input sense resistor select
  localparam logic [7:0] SONC_ADDR_OVNOC = 8'hB4;  // fixed overvoltage and neg. current limit
  localparam logic [7:0] SONC_ADDR_USERA = 8'hB5;  // user scratch a
  localparam logic [7:0] SONC_ADDR_USERB = 8'hB6;  // user scratch b
  localparam logic [7:0] SONC_ADDR_STAT = 8'hBA;   // vid bus status mirror

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SONC_OV_SEL_BIT = 3;  // fixed_ov_threshold_sel
  localparam int SONC_OV_DIS_BIT = 2;  // fixed_ov_disable
  localparam int SONC_USERA_LSB = 4;   // user scratch a field 7:4
  localparam int SONC_USERB_LSB = 5;   // user scratch b field 7:5

  // ---------------------------------------------------------------
  // values after reset (stand-ins for the backup copy load)
  // ---------------------------------------------------------------
  localparam logic [2:0] SONC_RST_SENSE = 3'h0;
  localparam logic [3:0] SONC_RST_OVNOC = 4'h0;
  localparam logic [3:0] SONC_RST_USERA = 4'h0;
  localparam logic [2:0] SONC_RST_USERB = 3'h0;
  localparam logic [4:0] SONC_RST_STAT = 5'h00;

  // ---------------------------------------------------------------
  // fixed overvoltage thresholds in mV, neg. current boundary in A
  // ---------------------------------------------------------------
  localparam logic [11:0] SONC_OV_5MV_LO = 12'd1500;
  localparam logic [11:0] SONC_OV_5MV_HI = 12'd1800;
  localparam logic [11:0] SONC_OV_10MV_LO = 12'd2400;
  localparam logic [11:0] SONC_OV_10MV_HI = 12'd3000;
  localparam logic [7:0] SONC_ICC_HIGH_A = 8'd15;

  // decoded sense setting: resistor 0.01 mOhm, gain 0.1 V/V, scale 0.1 A, lsb 10 uA
  typedef struct packed {
    logic [8:0] res_cmohm;
    logic [9:0] gain_x10;
    logic [9:0] full_scale_da;
    logic [14:0] lsb_10ua;
  } sonc_sense_t;

  // vid bus status bits: pending, dac high, max alert, thermal, settled
  typedef struct packed {
    logic second_status_pending;
    logic dac_above_target;
    logic max_current_alert;
    logic thermal_alert;
    logic regulator_settled;
  } sonc_stat_t;

endpackage

//--- sonc_regs.sv
// sense, fixed overvoltage, negative current and status mirror register group
module sonc_regs (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // byte register port
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic WR_UNLOCKED_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_ACK_O,
  output logic REG_NACK_O,
  // vid bus status events
  input wire sonc_pkg::sonc_stat_t VID_SET_I,
  input wire sonc_pkg::sonc_stat_t VID_CLR_I,
  // regulator side
  input wire logic [11:0] OUT_SENSE_MV_I,
  input wire logic [1:0] VOUT_STEP_PROTOCOL_CODE_I,
  input wire logic [7:0] MAX_CURRENT_A_I,
  output sonc_pkg::sonc_sense_t SENSE_CFG_O,
  output logic [7:0] NEG_OC_LIMIT_DA_O,
  output logic OVERVOLTAGE_FAULT_O,
  output logic HS_OFF_O,
  output logic LS_ON_O
);
  import sonc_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [2:0] input_sense_res_sel;  // sense select code
  logic [3:0] ovnoc;                // ov select, ov disable, neg limit select
  logic [3:0] user_a;               // scratch a field
  logic [2:0] user_b;               // scratch b field
  sonc_stat_t stat;                 // status mirror bits
  logic ov_latched;                 // fixed overvoltage fault latch
  logic [11:0] ov_threshold;        // active threshold in mV
  logic ov_trip;                    // comparator result
  logic wr_ok;                      // write accepted this cycle
  logic wr_map;                     // write hits a writable register
  logic [7:0] next_rdata;           // read data mux

  // ---------------------------------------------------------------
  // write acceptance
  // ---------------------------------------------------------------
  // only the four configuration registers take writes; mirror is read-only
  always_comb begin
    if (REG_ADDR_I == SONC_ADDR_SENSE) begin
      wr_map = 1'b1;
    end else if (REG_ADDR_I == SONC_ADDR_OVNOC) begin
      wr_map = 1'b1;
    end else if (REG_ADDR_I == SONC_ADDR_USERA) begin
      wr_map = 1'b1;
    end else if (REG_ADDR_I == SONC_ADDR_USERB) begin
      wr_map = 1'b1;
    end else begin
      wr_map = 1'b0;  // mirror and unmapped: refused
    end
  end

  // locked device refuses every write
  assign wr_ok = REG_WR_I && wr_map && WR_UNLOCKED_I;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // accepted writes land on the taking edge, no wait for conversion stop
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      input_sense_res_sel <= SONC_RST_SENSE;
      ovnoc <= SONC_RST_OVNOC;
      user_a <= SONC_RST_USERA;
      user_b <= SONC_RST_USERB;
    end else if (wr_ok) begin
      if (REG_ADDR_I == SONC_ADDR_SENSE) begin
        input_sense_res_sel <= REG_WDATA_I[2:0];
      end else if (REG_ADDR_I == SONC_ADDR_OVNOC) begin
        ovnoc <= REG_WDATA_I[3:0];
      end else if (REG_ADDR_I == SONC_ADDR_USERA) begin
        user_a <= REG_WDATA_I[7:SONC_USERA_LSB];
      end else if (REG_ADDR_I == SONC_ADDR_USERB) begin
        user_b <= REG_WDATA_I[7:SONC_USERB_LSB];
      end
    end
  end

  // ---------------------------------------------------------------
  // status mirror
  // ---------------------------------------------------------------
  // follows vid bus events; a set in the clearing cycle wins
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      stat <= SONC_RST_STAT;
    end else begin
      stat <= (stat & ~VID_CLR_I) | VID_SET_I;
    end
  end

  // ---------------------------------------------------------------
  // read mux and answer
  // ---------------------------------------------------------------
  // reserved bits are driven as zero, whatever was written
  always_comb begin
    if (REG_ADDR_I == SONC_ADDR_SENSE) begin
      next_rdata = {5'h00, input_sense_res_sel};
    end else if (REG_ADDR_I == SONC_ADDR_OVNOC) begin
      next_rdata = {4'h0, ovnoc};
    end else if (REG_ADDR_I == SONC_ADDR_USERA) begin
      next_rdata = {user_a, 4'h0};
    end else if (REG_ADDR_I == SONC_ADDR_USERB) begin
      next_rdata = {user_b, 5'h00};
    end else if (REG_ADDR_I == SONC_ADDR_STAT) begin
      next_rdata = {stat.second_status_pending, 3'h0, stat.dac_above_target,
                    stat.max_current_alert, stat.thermal_alert,
                    stat.regulator_settled};
    end else begin
      next_rdata = 8'h00;  // unmapped reads return zero
    end
  end

  // one-cycle answer pulse, data held until the next read
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      REG_ACK_O <= 1'b0;
      REG_NACK_O <= 1'b0;
      REG_RDATA_O <= 8'h00;
    end else begin
      REG_ACK_O <= REG_RD_I || wr_ok;
      REG_NACK_O <= REG_WR_I && !REG_RD_I && !wr_ok;
      if (REG_RD_I) begin
        REG_RDATA_O <= next_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // sense resistor decode
  // ---------------------------------------------------------------
  // table lookup from the select code
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      SENSE_CFG_O <= '0;
    end else begin
      case (input_sense_res_sel)
        3'h0: SENSE_CFG_O <= {9'd400, 10'd125, 10'd160, 15'd6250};
        3'h1: SENSE_CFG_O <= {9'd300, 10'd125, 10'd213, 15'd8330};
        3'h2: SENSE_CFG_O <= {9'd200, 10'd250, 10'd160, 15'd6250};
        3'h3: SENSE_CFG_O <= {9'd100, 10'd200, 10'd400, 15'd15625};
        3'h4: SENSE_CFG_O <= {9'd100, 10'd250, 10'd320, 15'd12500};
        3'h5: SENSE_CFG_O <= {9'd50, 10'd400, 10'd400, 15'd15625};
        3'h6: SENSE_CFG_O <= {9'd50, 10'd500, 10'd320, 15'd12500};
        default: SENSE_CFG_O <= {9'd25, 10'd500, 10'd640, 15'd25000};
      endcase
    end
  end

  // ---------------------------------------------------------------
  // negative overcurrent limit
  // ---------------------------------------------------------------
  // magnitude in 0.1 A; high table at 15 A and above, low table otherwise
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      NEG_OC_LIMIT_DA_O <= 8'd200;
    end else if (MAX_CURRENT_A_I >= SONC_ICC_HIGH_A) begin
      case (ovnoc[1:0])
        2'h0: NEG_OC_LIMIT_DA_O <= 8'd200;
        2'h1: NEG_OC_LIMIT_DA_O <= 8'd150;
        2'h2: NEG_OC_LIMIT_DA_O <= 8'd120;
        default: NEG_OC_LIMIT_DA_O <= 8'd100;
      endcase
    end else begin
      case (ovnoc[1:0])
        2'h0: NEG_OC_LIMIT_DA_O <= 8'd100;
        2'h1: NEG_OC_LIMIT_DA_O <= 8'd75;
        2'h2: NEG_OC_LIMIT_DA_O <= 8'd60;
        default: NEG_OC_LIMIT_DA_O <= 8'd50;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // fixed overvoltage detection
  // ---------------------------------------------------------------
  // threshold chosen by step size and select bit, independent of target
  always_comb begin
    if (VOUT_STEP_PROTOCOL_CODE_I == 2'h1 || VOUT_STEP_PROTOCOL_CODE_I == 2'h2) begin
      ov_threshold = ovnoc[SONC_OV_SEL_BIT] ? SONC_OV_5MV_HI : SONC_OV_5MV_LO;
    end else begin
      ov_threshold = ovnoc[SONC_OV_SEL_BIT] ? SONC_OV_10MV_HI : SONC_OV_10MV_LO;
    end
  end

  assign ov_trip = !ovnoc[SONC_OV_DIS_BIT] && (OUT_SENSE_MV_I > ov_threshold);

  // armed from the first edge after reset; latched response always applied
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ov_latched <= 1'b0;
    end else if (ov_trip) begin
      ov_latched <= 1'b1;
    end
  end

  assign OVERVOLTAGE_FAULT_O = ov_latched;
  assign HS_OFF_O = ov_latched;
  assign LS_ON_O = ov_latched;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  // register port answers
  a_locked_write_nack: assert property (
    REG_WR_I && !REG_RD_I && !WR_UNLOCKED_I |=> REG_NACK_O && !REG_ACK_O)
    else $error("locked write not refused");
  a_read_always_ack: assert property (
    REG_RD_I |=> REG_ACK_O)
    else $error("read not acknowledged");
  a_mirror_write_nack: assert property (
    REG_WR_I && !REG_RD_I && REG_ADDR_I == SONC_ADDR_STAT |=> REG_NACK_O && !REG_ACK_O)
    else $error("mirror write not refused");
  // reserved bits
  a_sense_reserved_zero: assert property (
    REG_RD_I && REG_ADDR_I == SONC_ADDR_SENSE |=> REG_RDATA_O[7:3] == 5'h00)
    else $error("sense reserved bits set");
  a_ovnoc_reserved_zero: assert property (
    REG_RD_I && REG_ADDR_I == SONC_ADDR_OVNOC |=> REG_RDATA_O[7:4] == 4'h0)
    else $error("limit reserved bits set");
  a_usera_low_zero: assert property (
    REG_RD_I && REG_ADDR_I == SONC_ADDR_USERA |=> REG_RDATA_O[3:0] == 4'h0)
    else $error("scratch a low bits set");
  a_userb_low_zero: assert property (
    REG_RD_I && REG_ADDR_I == SONC_ADDR_USERB |=> REG_RDATA_O[4:0] == 5'h00)
    else $error("scratch b low bits set");
  a_stat_gap_zero: assert property (
    REG_RD_I && REG_ADDR_I == SONC_ADDR_STAT |=> REG_RDATA_O[6:4] == 3'h0)
    else $error("mirror reserved bits set");
  // writes and decode tables
  a_write_immediate: assert property (
    wr_ok && REG_ADDR_I == SONC_ADDR_OVNOC |=> ovnoc == $past(REG_WDATA_I[3:0]))
    else $error("write not applied");
  a_sense_code3: assert property (
    input_sense_res_sel == 3'h3 |=> SENSE_CFG_O.lsb_10ua == 15'd15625)
    else $error("sense code 3 lsb wrong");
  a_sense_code7: assert property (
    input_sense_res_sel == 3'h7 |=> SENSE_CFG_O.full_scale_da == 10'd640)
    else $error("sense code 7 scale wrong");
  a_noc_low_table: assert property (
    MAX_CURRENT_A_I <= 8'd10 && ovnoc[1:0] == 2'h1 |=> NEG_OC_LIMIT_DA_O == 8'd75)
    else $error("neg limit wrong");
  a_noc_high_table: assert property (
    MAX_CURRENT_A_I >= 8'd15 && ovnoc[1:0] == 2'h0 |=> NEG_OC_LIMIT_DA_O == 8'd200)
    else $error("high neg limit wrong");
  // fixed overvoltage
  a_ov_latch_switches: assert property (
    ov_trip |=> (HS_OFF_O && LS_ON_O) [*2])
    else $error("fault response not latched");
  a_ov_hold: assert property (
    ov_latched |=> ov_latched)
    else $error("fault latch released");
  a_ov_armed: assert property (
    !ovnoc[SONC_OV_DIS_BIT] && OUT_SENSE_MV_I > 12'd3000 |=> OVERVOLTAGE_FAULT_O)
    else $error("detection not armed");
  a_ov_disabled: assert property (
    ovnoc[SONC_OV_DIS_BIT] && !ov_latched |=> !ov_latched)
    else $error("disabled detection tripped");
  a_ov_step5: assert property (
    !ovnoc[SONC_OV_DIS_BIT] && ovnoc[SONC_OV_SEL_BIT] && OUT_SENSE_MV_I == 12'd1801
    && (VOUT_STEP_PROTOCOL_CODE_I == 2'h1 || VOUT_STEP_PROTOCOL_CODE_I == 2'h2)
    |=> OVERVOLTAGE_FAULT_O)
    else $error("1.8 V threshold missed");
  a_ov_step10: assert property (
    !ovnoc[SONC_OV_SEL_BIT] && !ov_latched && VOUT_STEP_PROTOCOL_CODE_I == 2'h0
    && OUT_SENSE_MV_I == 12'd2400 |=> !ov_latched)
    else $error("2.4 V threshold early");
  // status mirror
  a_mirror_clear: assert property (
    VID_CLR_I.thermal_alert && !VID_SET_I.thermal_alert |=> !stat.thermal_alert)
    else $error("mirror bit not cleared");
  a_mirror_set: assert property (
    VID_SET_I.regulator_settled |=> stat.regulator_settled)
    else $error("mirror bit not set");
endmodule

//--- sonc_host_model.sv
// host model that issues single-byte requests on the register port
module sonc_host_model (
  // clock
  input wire logic clk_i,
  // request side
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic unlocked_o,
  // answer side
  input wire logic [7:0] rdata_i,
  input wire logic ack_i,
  input wire logic nack_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero, writes locked
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
    unlocked_o = 1'b0;
  end
  // level from the passcode logic that sits outside the block
  task automatic unlock(input logic u);
    @(negedge clk_i);
    unlocked_o = u;
  endtask
  // one request held a full cycle, answer taken half a cycle after the taking edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic [1:0] an);
    @(negedge clk_i);
    wr_o = w;
    rd_o = !w;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    q = rdata_i;
    an = {ack_i, nack_i};
    wr_o = 1'b0;
    rd_o = 1'b0;
    // released lines show no stale value
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule

//--- tb_top.sv
// self-checking bench for the sense, overvoltage and status register group
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sonc_pkg::*;
  // ------------------------------------------------------------
  // signals and expected tables
  // ------------------------------------------------------------
  logic clk, rst, wr, rd, unl, ack, nack, ovf, hs, ls;
  logic [7:0] addr, wdata, rdata, maxa, negl, q;
  logic [11:0] sense;
  logic [1:0] proto, an;
  sonc_stat_t vset, vclr;
  sonc_sense_t cfg;
  int err_total = 0;
  int check_count = 0;
  localparam logic [1:0] ACK = 2'h2;
  localparam logic [1:0] NAK = 2'h1;
  logic [7:0] adr [6] = '{SONC_ADDR_SENSE, SONC_ADDR_OVNOC, SONC_ADDR_USERA,
                          SONC_ADDR_USERB, SONC_ADDR_STAT, 8'h00};
  logic [7:0] msk [4] = '{8'h07, 8'h0F, 8'hF0, 8'hE0};
  logic [7:0] nexp [8] = '{8'hC8, 8'h96, 8'h78, 8'h64, 8'h64, 8'h4B, 8'h3C, 8'h32};
  logic [11:0] thr [4] = '{12'h5DC, 12'h708, 12'h960, 12'hBB8};
  logic [1:0] pc [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
  sonc_sense_t stab [8] = '{
    {9'h190, 10'h07D, 10'h0A0, 15'h186A}, {9'h12C, 10'h07D, 10'h0D5, 15'h208A},
    {9'h0C8, 10'h0FA, 10'h0A0, 15'h186A}, {9'h064, 10'h0C8, 10'h190, 15'h3D09},
    {9'h064, 10'h0FA, 10'h140, 15'h30D4}, {9'h032, 10'h190, 10'h190, 15'h3D09},
    {9'h032, 10'h1F4, 10'h140, 15'h30D4}, {9'h019, 10'h1F4, 10'h280, 15'h61A8}};
  // ------------------------------------------------------------
  // design, host and clock
  // ------------------------------------------------------------
  sonc_regs uut (.CLK_I(clk), .RST_I(rst), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .WR_UNLOCKED_I(unl), .REG_RDATA_O(rdata),
    .REG_ACK_O(ack), .REG_NACK_O(nack), .VID_SET_I(vset), .VID_CLR_I(vclr),
    .OUT_SENSE_MV_I(sense), .VOUT_STEP_PROTOCOL_CODE_I(proto), .MAX_CURRENT_A_I(maxa),
    .SENSE_CFG_O(cfg), .NEG_OC_LIMIT_DA_O(negl), .OVERVOLTAGE_FAULT_O(ovf),
    .HS_OFF_O(hs), .LS_ON_O(ls));
  sonc_host_model host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr),
    .wdata_o(wdata), .unlocked_o(unl), .rdata_i(rdata), .ack_i(ack), .nack_i(nack));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic close_out();
    if (err_total == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
    host.xfer(1'b1, a, d, q, an);
    chk(an, e, "write answer");
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00, q, an);
    chk({an, q}, {ACK, e}, "read answer");
  endtask
  // reset held six cycles, released off the sampling edge
  task automatic do_reset();
    @(negedge clk);
    rst = 1'b1;
    sense = 12'h000;
    repeat (6) @(negedge clk);
    rst = 1'b0;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    vset = 5'h00;
    vclr = 5'h00;
    sense = 12'h000;
    proto = 2'h0;
    maxa = 8'h0F;
    do_reset();
    @(negedge clk);
    chk(cfg, stab[0], "sense after reset");
    foreach (adr[i]) rd_reg(adr[i], 8'h00);
    wr_reg(SONC_ADDR_OVNOC, 8'h0F, NAK);
    rd_reg(SONC_ADDR_OVNOC, 8'h00);
    host.unlock(1'b1);
    // reserved bits stay zero whatever is written
    for (int i = 0; i < 4; i++) begin
      wr_reg(adr[i], 8'hFF, ACK);
      rd_reg(adr[i], msk[i]);
    end
    wr_reg(8'h00, 8'h55, NAK);
    // every sense code reaches the decoded outputs one cycle after the write lands
    for (int i = 0; i < 8; i++) begin
      wr_reg(SONC_ADDR_SENSE, 8'(i), ACK);
      @(negedge clk);
      chk(cfg, stab[i], "sense entry");
    end
    // negative limit, high table at the 15 A boundary, then low table
    for (int i = 0; i < 8; i++) begin
      maxa = (i < 4) ? 8'h0F : 8'h0A;
      wr_reg(SONC_ADDR_OVNOC, 8'h04 | 8'(i % 4), ACK);
      @(negedge clk);
      chk(negl, nexp[i], "neg limit");
    end
    // each status bit lands in its own place and clears from the vid side
    for (int j = 0; j < 5; j++) begin
      vset = 5'(1 << j);
      @(negedge clk);
      vset = 5'h00;
      rd_reg(SONC_ADDR_STAT, 8'(1 << ((j == 4) ? 7 : j)));
      vclr = 5'(1 << j);
      @(negedge clk);
      vclr = 5'h00;
    end
    rd_reg(SONC_ADDR_STAT, 8'h00);
    vset = 5'h1F;
    @(negedge clk);
    vset = 5'h00;
    wr_reg(SONC_ADDR_STAT, 8'h00, NAK);
    rd_reg(SONC_ADDR_STAT, 8'h8F);
    vclr = 5'h12;
    @(negedge clk);
    vclr = 5'h00;
    rd_reg(SONC_ADDR_STAT, 8'h0D);
    // set and clear of one bit in the same cycle: the set wins
    vset = 5'h02;
    vclr = 5'h02;
    @(negedge clk);
    vset = 5'h00;
    vclr = 5'h00;
    rd_reg(SONC_ADDR_STAT, 8'h0F);
    // detection disabled: far over every threshold, no trip
    sense = 12'hFFF;
    repeat (3) @(negedge clk);
    chk({ovf, hs, ls}, 3'h0, "trip while disabled");
    // each protocol code and threshold select, one fresh reset apiece
    for (int k = 0; k < 4; k++) begin
      do_reset();
      proto = pc[k];
      // select bit lands before the sense level rises, so no early trip
      if (k % 2 == 1) wr_reg(SONC_ADDR_OVNOC, 8'h08, ACK);
      sense = thr[k];
      repeat (2) @(negedge clk);
      chk({ovf, hs, ls}, 3'h0, "trip at threshold");
      sense = thr[k] + 12'h001;
      @(negedge clk);
      chk({ovf, hs, ls}, 3'h7, "no trip above threshold");
      sense = 12'h000;
      repeat (3) @(negedge clk);
      chk({ovf, hs, ls}, 3'h7, "fault not latched");
    end
    close_out();
  end
  // watchdog, far beyond the under two hundred cycles the tests need
  initial begin
    #200000;
    err_total++;
    close_out();
  end
endmodule
